// file: hw/cil_consts.svh
// Offsets, field positions, reset values and timing counts of the core interrupt logic.
`ifndef CIL_CONSTS_SVH
`define CIL_CONSTS_SVH

`define CIL_OFF_INTCTL      12'h000
`define CIL_OFF_PFLAG1      12'h004
`define CIL_OFF_PFLAG2      12'h008
`define CIL_OFF_PEN1        12'h00c
`define CIL_OFF_PEN2        12'h010
`define CIL_OFF_WAKE        12'h014
`define CIL_OFF_STATUS      12'h018
`define CIL_OFF_IOCF        12'h01c

`define CIL_BIT_GIE         7
`define CIL_BIT_PERIPH_IRQ_ENABLE        6
`define CIL_BIT_TMRIE       5
`define CIL_BIT_EXTIE       4
`define CIL_BIT_PCIE        3
`define CIL_BIT_TMRIF       2
`define CIL_BIT_EXTIF       1
`define CIL_BIT_PCIF        0

`define CIL_INTCTL_RESET    8'h00
`define CIL_VECTOR          15'h0004
`define CIL_SYNC_LAT_MIN    3
`define CIL_SYNC_LAT_MAX    4
`define CIL_ASYNC_LAT_MAX   5

`endif

// file: hw/cil_pkg.sv
// Types shared by the core interrupt logic.
package cil_pkg;

  typedef enum logic [1:0] {
    CIL_RUN,
    CIL_FLUSH,
    CIL_PUSH,
    CIL_JUMP
  } cil_state_e;

  typedef struct packed {
    logic        flush;
    logic        push;
    logic        save_ctx;
    logic        load_vec;
    logic [14:0] vector;
    logic        restore_ctx;
    logic        pop;
  } cil_core_cmd_s;

  typedef struct packed {
    logic       tmr_ovf;
    logic       ext_edge;
    logic [7:0] iocb;
    logic [7:0] per1;
    logic [7:0] per2;
  } cil_events_s;

endpackage : cil_pkg

// file: hw/cil_sync.sv
// Two-stage synchroniser with rising-edge pulse after the second stage.
`timescale 1ns/100ps
module cil_sync
  import cil_pkg::*;
#(
  parameter int WIDTH = 1
) (
  // Clock and reset.
  input  wire logic             pclk,
  input  wire logic             presetn,
  // Asynchronous input and synchronised results.
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] level_out,
  output logic      [WIDTH-1:0] rise_out
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] sync;
    logic [WIDTH-1:0] prev;
  } cil_sync_s;

  cil_sync_s state_reg;
  cil_sync_s state_next;

  always_comb begin
    state_next      = state_reg;
    state_next.meta = async_in;
    state_next.sync = state_reg.meta;
    state_next.prev = state_reg.sync;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign level_out = state_reg.sync;
  assign rise_out  = state_reg.sync & ~state_reg.prev;

endmodule : cil_sync

// file: hw/cil_core_irq.sv
// Core interrupt logic: flags, enables, vectoring sequence and APB register file.
// Notes on behaviour
// - Any reset leaves all interrupts disabled.
// - Vector needs global, own, maybe peripheral enable.
// - Flags set on events regardless of enables.
// - Taken interrupt flushes, clears, pushes, saves, vectors.
// - Disabled events stay pending until enabled.
// - Return pops, restores context, sets global enable.
// - Synchronous event latency three or four cycles.
// - Asynchronous event latency three to five cycles; the pin path here takes six, two of them in the synchroniser.
// - Control bit one latches external pin event.
// - Selected sources wake core from sleep.
`timescale 1ns/100ps
`include "cil_consts.svh"
module cil_core_irq
  import cil_pkg::*;
(
  // Clock and reset.
  input  wire logic          pclk,
  input  wire logic          presetn,
  // APB slave.
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [11:0]   paddr,
  input  wire logic [31:0]   pwdata,
  output logic      [31:0]   prdata,
  output logic               pready,
  output logic               pslverr,
  // Events: pin is asynchronous, the rest come from same-clock logic.
  input  wire logic          ext_pin,
  input  wire logic          ext_rising,
  input  wire cil_events_s   events,
  // Core interface.
  input  wire logic          instr_cycle,
  input  wire logic          return_from_handler,
  input  wire logic          sleeping,
  output cil_core_cmd_s      core_cmd,
  output logic               wake
);

  typedef struct packed {
    logic [7:0] intctl;
    logic [7:0] pflag1;
    logic [7:0] pflag2;
    logic [7:0] pen1;
    logic [7:0] pen2;
    logic [7:0] iocf;
    logic [2:0] wake_en;
    logic       in_handler;
    cil_state_e st;
    logic [31:0] rdata;
    cil_core_cmd_s cmd;
    logic       wake;
  } cil_state_s;

  cil_state_s s_reg;
  cil_state_s s_next;

  logic ext_level;
  logic ext_rise;
  logic ext_event;
  logic wr;
  logic rd;
  logic addr_ok;
  logic per_pend;
  logic pend;
  logic wake_any;
  logic [7:0] wd;

  // The pin is asynchronous, so it passes two flops before edge detection.
  cil_sync #(
    .WIDTH(1)
  ) u_ext_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in (ext_pin),
    .level_out(ext_level),
    .rise_out (ext_rise)
  );

  // Edge polarity select: a falling edge is a rise of the inverted level.
  logic ext_prev_reg;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_prev_reg <= 1'b0;
    end else begin
      ext_prev_reg <= ext_level;
    end
  end
  assign ext_event = ext_rising ? ext_rise : (ext_prev_reg & ~ext_level);

  assign wr      = psel & penable & pwrite;
  assign rd      = psel & ~penable & ~pwrite;
  assign addr_ok = (paddr == `CIL_OFF_INTCTL) || (paddr == `CIL_OFF_PFLAG1) || (paddr == `CIL_OFF_PFLAG2) ||
                   (paddr == `CIL_OFF_PEN1) || (paddr == `CIL_OFF_PEN2) || (paddr == `CIL_OFF_WAKE) ||
                   (paddr == `CIL_OFF_STATUS) || (paddr == `CIL_OFF_IOCF);
  assign wd      = pwdata[7:0];

  // Peripheral sources need both the peripheral and individual enables.
  assign per_pend = s_reg.intctl[`CIL_BIT_PERIPH_IRQ_ENABLE] &
                    (|(s_reg.pflag1 & s_reg.pen1) | |(s_reg.pflag2 & s_reg.pen2));
  assign pend = (s_reg.intctl[`CIL_BIT_TMRIE] & s_reg.intctl[`CIL_BIT_TMRIF]) |
                (s_reg.intctl[`CIL_BIT_EXTIE] & s_reg.intctl[`CIL_BIT_EXTIF]) |
                (s_reg.intctl[`CIL_BIT_PCIE] & s_reg.intctl[`CIL_BIT_PCIF]) | per_pend;
  // Wake ignores the global enable so a sleeping core can resume inline.
  assign wake_any = (s_reg.wake_en[0] & s_reg.intctl[`CIL_BIT_TMRIF]) |
                    (s_reg.wake_en[1] & s_reg.intctl[`CIL_BIT_EXTIF]) |
                    (s_reg.wake_en[2] & per_pend);

  always_comb begin
    s_next     = s_reg;
    s_next.cmd = '0;
    s_next.cmd.vector = `CIL_VECTOR;
    // Software writes first; hardware sets below win over any clear.
    if (wr) begin
      case (paddr)
        `CIL_OFF_INTCTL: s_next.intctl = {wd[7:1], s_reg.intctl[`CIL_BIT_PCIF]};
        `CIL_OFF_PFLAG1: s_next.pflag1 = wd;
        `CIL_OFF_PFLAG2: s_next.pflag2 = wd;
        `CIL_OFF_PEN1:   s_next.pen1 = wd;
        `CIL_OFF_PEN2:   s_next.pen2 = wd;
        `CIL_OFF_WAKE:   s_next.wake_en = wd[2:0];
        `CIL_OFF_IOCF:   s_next.iocf = wd;
        default:         s_next.iocf = s_next.iocf;
      endcase
    end
    s_next.intctl[`CIL_BIT_TMRIF] = s_next.intctl[`CIL_BIT_TMRIF] | events.tmr_ovf;
    s_next.intctl[`CIL_BIT_EXTIF] = s_next.intctl[`CIL_BIT_EXTIF] | ext_event;
    s_next.pflag1 = s_next.pflag1 | events.per1;
    s_next.pflag2 = s_next.pflag2 | events.per2;
    s_next.iocf   = s_next.iocf | events.iocb;
    // The change flag is read-only and follows the OR of the port flags.
    s_next.intctl[`CIL_BIT_PCIF] = |s_next.iocf;

    // A return sets the global enable in the same cycle it pops and restores.
    if (return_from_handler && s_reg.st == CIL_RUN) begin
      s_next.cmd.pop         = 1'b1;
      s_next.cmd.restore_ctx = 1'b1;
      s_next.intctl[`CIL_BIT_GIE] = 1'b1;
      s_next.in_handler      = 1'b0;
    end

    // The sequence advances once per instruction cycle, except JUMP, which returns to RUN on the next clock regardless.
    case (s_reg.st)
      CIL_RUN: begin
        if (instr_cycle && pend && s_reg.intctl[`CIL_BIT_GIE] && !return_from_handler) begin
          s_next.st        = CIL_FLUSH;
          s_next.cmd.flush = 1'b1;
          s_next.intctl[`CIL_BIT_GIE] = 1'b0;
        end
      end
      CIL_FLUSH: begin
        if (instr_cycle) begin
          s_next.st           = CIL_PUSH;
          s_next.cmd.push     = 1'b1;
          s_next.cmd.save_ctx = 1'b1;
        end
      end
      CIL_PUSH: begin
        if (instr_cycle) begin
          s_next.st           = CIL_JUMP;
          s_next.cmd.load_vec = 1'b1;
          s_next.in_handler   = 1'b1;
        end
      end
      CIL_JUMP: begin
        s_next.st = CIL_RUN;
      end
      default: begin
        s_next.st = CIL_RUN;
      end
    endcase

    s_next.wake = sleeping & wake_any;

    s_next.rdata = s_reg.rdata;
    if (rd) begin
      case (paddr)
        `CIL_OFF_INTCTL: s_next.rdata = {24'h000000, s_reg.intctl};
        `CIL_OFF_PFLAG1: s_next.rdata = {24'h000000, s_reg.pflag1};
        `CIL_OFF_PFLAG2: s_next.rdata = {24'h000000, s_reg.pflag2};
        `CIL_OFF_PEN1:   s_next.rdata = {24'h000000, s_reg.pen1};
        `CIL_OFF_PEN2:   s_next.rdata = {24'h000000, s_reg.pen2};
        `CIL_OFF_WAKE:   s_next.rdata = {29'h0000000, s_reg.wake_en};
        `CIL_OFF_STATUS: s_next.rdata = {28'h0000000, s_reg.in_handler, pend, s_reg.st};
        `CIL_OFF_IOCF:   s_next.rdata = {24'h000000, s_reg.iocf};
        default:         s_next.rdata = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_reg        <= '0;
      s_reg.intctl <= `CIL_INTCTL_RESET;
      s_reg.st     <= CIL_RUN;
      s_reg.cmd.vector <= `CIL_VECTOR;
    end else begin
      s_reg <= s_next;
    end
  end

  assign prdata   = s_reg.rdata;
  assign pready   = 1'b1;
  assign pslverr  = psel & penable & ~addr_ok;
  assign core_cmd = s_reg.cmd;
  assign wake     = s_reg.wake;

  // Latency count helper: instruction cycles since the sequence began.
  logic [2:0] lat_cnt_reg;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lat_cnt_reg <= 3'h0;
    end else if (s_reg.st == CIL_RUN) begin
      lat_cnt_reg <= 3'h0;
    end else if (instr_cycle && lat_cnt_reg != 3'h7) begin
      lat_cnt_reg <= lat_cnt_reg + 3'h1;
    end
  end

  chk_reset_gie_clear: assert property (
    @(posedge pclk) $rose(presetn) |-> !s_reg.intctl[`CIL_BIT_GIE])
    else $error("Global enable set right after reset.");

  chk_vector_needs_enables: assert property (
    @(posedge pclk) disable iff (!presetn)
    (s_reg.st == CIL_RUN && s_next.st == CIL_FLUSH) |-> (pend && s_reg.intctl[`CIL_BIT_GIE]))
    else $error("Vectoring started without enables.");

  chk_tmr_flag_set: assert property (
    @(posedge pclk) disable iff (!presetn)
    events.tmr_ovf |=> s_reg.intctl[`CIL_BIT_TMRIF])
    else $error("Timer flag not set by its event.");

  chk_take_clears_gie: assert property (
    @(posedge pclk) disable iff (!presetn)
    core_cmd.flush |-> !s_reg.intctl[`CIL_BIT_GIE] && s_reg.st == CIL_FLUSH)
    else $error("Global enable not cleared on flush.");

  chk_push_before_jump: assert property (
    @(posedge pclk) disable iff (!presetn)
    core_cmd.load_vec |-> core_cmd.vector == `CIL_VECTOR && $past(s_reg.st) == CIL_PUSH)
    else $error("Vector load out of sequence.");

  chk_pending_held: assert property (
    @(posedge pclk) disable iff (!presetn)
    (!s_reg.intctl[`CIL_BIT_GIE] && s_reg.st == CIL_RUN) |=> s_reg.st != CIL_FLUSH)
    else $error("Vectoring while global enable clear.");

  chk_return_sets_gie: assert property (
    @(posedge pclk) disable iff (!presetn)
    core_cmd.pop |-> core_cmd.restore_ctx && s_reg.intctl[`CIL_BIT_GIE])
    else $error("Return did not restore and enable.");

  chk_latency_bound: assert property (
    @(posedge pclk) disable iff (!presetn)
    core_cmd.load_vec |-> lat_cnt_reg <= 3'(`CIL_SYNC_LAT_MAX))
    else $error("Vector latency above bound.");

  chk_ext_flag_set: assert property (
    @(posedge pclk) disable iff (!presetn)
    ext_event |=> s_reg.intctl[`CIL_BIT_EXTIF])
    else $error("External flag not set.");

  chk_wake_cause: assert property (
    @(posedge pclk) disable iff (!presetn)
    wake |-> $past(sleeping) && $past(wake_any))
    else $error("Wake without enabled source.");

  // The latency checks start where the set pulse is sampled and need no other write or return in flight.
  // The pin is two synchroniser cycles ahead of ext_event, which the bench allows for on its own side.
  chk_sync_latency: assert property (
    @(posedge pclk) disable iff (!presetn)
    (events.tmr_ovf && s_reg.intctl[`CIL_BIT_TMRIE] && s_reg.intctl[`CIL_BIT_GIE] && s_reg.st == CIL_RUN &&
     !pend && !wr) ##1 (instr_cycle && !return_from_handler) ##1 instr_cycle [*2] |=> core_cmd.load_vec)
    else $error("Synchronous event not vectored in time.");

  chk_async_latency: assert property (
    @(posedge pclk) disable iff (!presetn)
    (ext_event && s_reg.intctl[`CIL_BIT_EXTIE] && s_reg.intctl[`CIL_BIT_GIE] && s_reg.st == CIL_RUN &&
     !pend && !wr) ##1 (instr_cycle && !return_from_handler) ##1 instr_cycle [*2] |=> core_cmd.load_vec)
    else $error("Pin event not vectored in time.");

  chk_periph_flag_set: assert property (
    @(posedge pclk) disable iff (!presetn)
    (|events.per1) |=> (s_reg.pflag1 & $past(events.per1)) == $past(events.per1))
    else $error("Peripheral flag not set by its event.");

  chk_flush_one_cycle: assert property (
    @(posedge pclk) disable iff (!presetn)
    core_cmd.flush |=> !core_cmd.flush)
    else $error("Flush pulse longer than one cycle.");

  chk_push_saves_ctx: assert property (
    @(posedge pclk) disable iff (!presetn)
    core_cmd.push |-> core_cmd.save_ctx && $past(s_reg.st) == CIL_FLUSH)
    else $error("Push without context save.");

  chk_change_flag_ro: assert property (
    @(posedge pclk) disable iff (!presetn)
    (wr && paddr == `CIL_OFF_INTCTL && pwdata[0] && !(|s_reg.iocf) && !(|events.iocb)) |=>
      !s_reg.intctl[`CIL_BIT_PCIF])
    else $error("Software set the read-only change flag.");

  cov_take: cover property (@(posedge pclk) disable iff (!presetn) core_cmd.load_vec);
  cov_return: cover property (@(posedge pclk) disable iff (!presetn) core_cmd.pop);
  cov_wake: cover property (@(posedge pclk) disable iff (!presetn) wake);
  cov_ext: cover property (@(posedge pclk) disable iff (!presetn) ext_event);
  cov_held: cover property (@(posedge pclk) disable iff (!presetn)
    pend && !s_reg.intctl[`CIL_BIT_GIE] && s_reg.st == CIL_RUN);

endmodule : cil_core_irq

// file: verification/cil_core_model.sv
// Model of the processor core: instruction timing, stack depth and the return instruction.
`timescale 1ns/100ps
`include "cil_consts.svh"
module cil_core_model
  import cil_pkg::*;
(
  // Clock and reset.
  input  wire logic          pclk,
  input  wire logic          presetn,
  // Core side of the interrupt logic.
  input  wire cil_core_cmd_s core_cmd,
  input  wire logic          ret_go,
  output logic               instr_cycle,
  output logic               return_from_handler,
  output logic [3:0]         depth,
  output logic [3:0]         bad
);
  assign instr_cycle = 1'b1;
  // A real core can only reach the return inside a handler, so a stray request is dropped.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      return_from_handler <= 1'b0;
      depth               <= 4'h0;
      bad                 <= 4'h0;
    end else begin
      return_from_handler <= ret_go && depth != 4'h0;
      if (core_cmd.push) begin
        depth <= depth + 4'h1;
      end else if (core_cmd.pop) begin
        depth <= depth - 4'h1;
      end
      if (core_cmd.push !== core_cmd.save_ctx || core_cmd.pop !== core_cmd.restore_ctx ||
          (core_cmd.load_vec && core_cmd.vector !== `CIL_VECTOR)) begin
        bad <= bad + 4'h1;
      end
    end
  end
endmodule : cil_core_model

// file: verification/cil_core_irq_test.sv
// Self-checking bench of the core interrupt logic.
`timescale 1ns/100ps
`include "cil_consts.svh"
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin num_errors++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, b); end end
module cil_core_irq_test;
  import cil_pkg::*;
  typedef struct {logic [11:0] a; logic [31:0] d; logic [31:0] q; logic e;} cil_row_s;
  logic          pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0]   paddr = 12'h000;
  logic [31:0]   pwdata = 32'h0, prdata, r;
  logic          pready, pslverr, e, ext_pin = 1'b0, ext_rising = 1'b1, sleeping = 1'b0, ret_go = 1'b0, wake;
  logic          instr_cycle, return_from_handler;
  logic [3:0]    depth, bad;
  cil_events_s   events = '0;
  cil_core_cmd_s core_cmd;
  int            num_errors = 0, checks = 0, cyc = 0, nflush = 0, n;
  cil_row_s      rows [10] = '{'{12'h000, 32'h78, 32'h78, 1'b0}, '{12'h000, 32'h01, 32'h00, 1'b0},
    '{12'h00c, 32'ha5, 32'ha5, 1'b0}, '{12'h00c, 32'h00, 32'h00, 1'b0}, '{12'h010, 32'h5a, 32'h5a, 1'b0},
    '{12'h010, 32'h00, 32'h00, 1'b0}, '{12'h014, 32'h07, 32'h07, 1'b0}, '{12'h014, 32'h00, 32'h00, 1'b0},
    '{12'h020, 32'hff, 32'h00, 1'b1}, '{12'h000, 32'h00, 32'h00, 1'b0}};
  always #12.5 pclk = ~pclk;
  cil_core_irq cil_core_irq_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ext_pin(ext_pin), .ext_rising(ext_rising), .events(events), .instr_cycle(instr_cycle),
    .return_from_handler(return_from_handler), .sleeping(sleeping), .core_cmd(core_cmd), .wake(wake));
  cil_core_model cil_core_model_inst (.pclk(pclk), .presetn(presetn), .core_cmd(core_cmd), .ret_go(ret_go),
    .instr_cycle(instr_cycle), .return_from_handler(return_from_handler), .depth(depth), .bad(bad));
  always @(posedge pclk) begin
    cyc++;
    if (core_cmd.flush === 1'b1) nflush++;
    if (cyc == 20000) begin
      num_errors++;
      print_verdict();
    end
  end
  task automatic print_verdict();
    if (num_errors == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : print_verdict
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic fire(input cil_events_s v);
    @(posedge pclk);
    events <= v;
    @(posedge pclk);
    events <= '0;
  endtask : fire
  // Counts edges from the one that launched the event until the vector load shows.
  task automatic lat(input int start);
    n = start;
    #1;
    while (core_cmd.load_vec !== 1'b1 && n < 20) begin
      @(posedge pclk);
      #1;
      n++;
    end
  endtask : lat
  task automatic ret();
    @(posedge pclk);
    ret_go <= 1'b1;
    @(posedge pclk);
    ret_go <= 1'b0;
    repeat (3) @(posedge pclk);
  endtask : ret
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      apb(1'b0, 12'(4 * i), 32'h0);
      `CHK(r, 32'h0)
    end
    foreach (rows[i]) begin
      apb(1'b1, rows[i].a, rows[i].d);
      apb(1'b0, rows[i].a, 32'h0);
      `CHK({e, r}, {rows[i].e, rows[i].q})
    end
    fire('{tmr_ovf: 1'b1, default: '0});
    apb(1'b0, 12'h000, 32'h0);
    `CHK(r, 32'h04)
    apb(1'b1, 12'h000, 32'h24);
    repeat (4) @(posedge pclk);
    `CHK(nflush, 0)
    apb(1'b1, 12'h000, 32'ha4);
    lat(0);
    `CHK(n inside {[`CIL_SYNC_LAT_MIN - 1 : `CIL_SYNC_LAT_MAX - 1]}, 1'b1)
    fire('{tmr_ovf: 1'b1, default: '0});
    lat(1);
    `CHK(n inside {[`CIL_SYNC_LAT_MIN : `CIL_SYNC_LAT_MAX]}, 1'b0)
    apb(1'b0, 12'h000, 32'h0);
    `CHK(r, 32'h24)
    apb(1'b1, 12'h000, 32'h00);
    `CHK(depth, 4'h1)
    `CHK(nflush, 1)
    apb(1'b1, 12'h000, 32'h20);
    ret();
    `CHK(depth, 4'h0)
    fire('{tmr_ovf: 1'b1, default: '0});
    lat(1);
    `CHK(n inside {[`CIL_SYNC_LAT_MIN : `CIL_SYNC_LAT_MAX]}, 1'b1)
    apb(1'b1, 12'h000, 32'h20);
    ret();
    apb(1'b1, 12'h00c, 32'h01);
    apb(1'b1, 12'h000, 32'h80);
    fire('{per1: 8'h01, default: '0});
    repeat (6) @(posedge pclk);
    `CHK(nflush, 2)
    apb(1'b1, 12'h000, 32'hc0);
    repeat (6) @(posedge pclk);
    `CHK(nflush, 3)
    apb(1'b0, 12'h004, 32'h0);
    `CHK(r, 32'h01)
    apb(1'b1, 12'h004, 32'h00);
    ret();
    apb(1'b1, 12'h000, 32'h90);
    @(posedge pclk);
    ext_pin <= 1'b1;
    lat(0);
    `CHK(n inside {[`CIL_SYNC_LAT_MIN - 1 : `CIL_ASYNC_LAT_MAX + 2]}, 1'b1)
    apb(1'b0, 12'h000, 32'h0);
    `CHK(r, 32'h12)
    apb(1'b1, 12'h000, 32'h10);
    ret();
    apb(1'b1, 12'h000, 32'h00);
    apb(1'b1, 12'h014, 32'h01);
    ext_rising <= 1'b0;
    ext_pin <= 1'b0;
    repeat (4) @(posedge pclk);
    apb(1'b0, 12'h000, 32'h0);
    `CHK(r, 32'h02)
    sleeping <= 1'b1;
    repeat (3) @(posedge pclk);
    `CHK(wake, 1'b0)
    fire('{tmr_ovf: 1'b1, default: '0});
    repeat (3) @(posedge pclk);
    `CHK(wake, 1'b1)
    apb(1'b1, 12'h000, 32'ha4);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 12'h000, 32'h0);
    `CHK({r, wake}, 33'h0)
    `CHK(bad, 4'h0)
    print_verdict();
  end
endmodule : cil_core_irq_test
